// File: inc/tapt_defs.svh
`ifndef TAPT_DEFS_SVH
`define TAPT_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TAPT_OFS_EVT_CFG     8'h21
`define TAPT_OFS_EVT_SRC     8'h22
`define TAPT_OFS_THR_X       8'h23
`define TAPT_OFS_THR_Y       8'h24
`define TAPT_OFS_THR_Z       8'h25
`define TAPT_OFS_DURATION    8'h26
`define TAPT_OFS_LATENCY     8'h27
`define TAPT_OFS_WINDOW      8'h28

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define TAPT_RST_BYTE        8'h00
`define TAPT_RST_THR         7'h00
`define TAPT_CFG_LATCH_BIT   6
`define TAPT_SRC_ACTIVE_BIT  7
`define TAPT_SRC_DOUBLE_BIT  3
`define TAPT_COUNT_FULL      8'hFF

// ----------------------------------------------------------------
// time base: steps counted in units of 0.625 ms
// ----------------------------------------------------------------
`define TAPT_BASE_TICK_NS    625000
`define TAPT_CLK_PERIOD_NS   8
`define TAPT_UNIT_ONE        11'h001

// sample period per rate code, in base units
`define TAPT_PER_800         11'h002
`define TAPT_PER_400         11'h004
`define TAPT_PER_200         11'h008
`define TAPT_PER_100         11'h010
`define TAPT_PER_50          11'h020
`define TAPT_PER_12P5        11'h080
`define TAPT_PER_6P25        11'h100
`define TAPT_PER_1P56        11'h400
`define TAPT_RATE_400        3'h1

// duration step caps, filter on
`define TAPT_CAP_ON_NORMAL   11'h020
`define TAPT_CAP_ON_LOW_POWER_LOW_NOISE_MODE     11'h080
`define TAPT_CAP_ON_HIRES    11'h004
`define TAPT_CAP_ON_LP       11'h100
// duration step caps, filter off
`define TAPT_CAP_OFF_NORMAL  11'h008
`define TAPT_CAP_OFF_LOW_POWER_LOW_NOISE_MODE    11'h020
`define TAPT_CAP_OFF_HIRES   11'h001
`define TAPT_CAP_OFF_LP      11'h040

`endif

// File: inc/tapt_pkg.sv
package tapt_pkg;

	typedef enum logic [1:0] {
		TAPT_MODE_NORMAL = 2'h0,
		TAPT_MODE_LOW_POWER_LOW_NOISE_MODE   = 2'h1,
		TAPT_MODE_HIRES  = 2'h2,
		TAPT_MODE_LP     = 2'h3
	} tapt_mode_t;

	typedef enum logic [4:0] {
		TAPT_IDLE    = 5'h01,
		TAPT_PULSE1  = 5'h02,
		TAPT_LATENCY = 5'h04,
		TAPT_WINDOW  = 5'h08,
		TAPT_PULSE2  = 5'h10
	} tapt_state_t;

	typedef struct packed {
		logic       neg;
		logic [7:0] mag;
	} tapt_axis_t;

	typedef tapt_axis_t [2:0] tapt_axes_t;

	typedef struct packed {
		logic [2:0]  sample_rate;
		tapt_mode_t  mode;
		logic        tap_filter_enable;
	} tapt_timebase_t;

endpackage

// File: hw/tapt_step_sel.sv
`timescale 1ns/100ps
`include "tapt_defs.svh"

module tapt_step_sel
	import tapt_pkg::*;
(
	input  wire tapt_timebase_t tb,
	output logic [10:0]         dur_step,
	output logic [10:0]         lat_step
);

	function automatic logic [10:0] period_of(input logic [2:0] r);
		case (r)
			3'h0: period_of = `TAPT_PER_800;
			3'h1: period_of = `TAPT_PER_400;
			3'h2: period_of = `TAPT_PER_200;
			3'h3: period_of = `TAPT_PER_100;
			3'h4: period_of = `TAPT_PER_50;
			3'h5: period_of = `TAPT_PER_12P5;
			3'h6: period_of = `TAPT_PER_6P25;
			default: period_of = `TAPT_PER_1P56;
		endcase
	endfunction

	function automatic logic [10:0] cap_of(input tapt_mode_t m, input logic f);
		case (m)
			TAPT_MODE_NORMAL: cap_of = f ? `TAPT_CAP_ON_NORMAL : `TAPT_CAP_OFF_NORMAL;
			TAPT_MODE_LOW_POWER_LOW_NOISE_MODE:   cap_of = f ? `TAPT_CAP_ON_LOW_POWER_LOW_NOISE_MODE : `TAPT_CAP_OFF_LOW_POWER_LOW_NOISE_MODE;
			TAPT_MODE_HIRES:  cap_of = f ? `TAPT_CAP_ON_HIRES : `TAPT_CAP_OFF_HIRES;
			default:          cap_of = f ? `TAPT_CAP_ON_LP : `TAPT_CAP_OFF_LP;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// duration step, latency and window step is twice that
	// ----------------------------------------------------------------
	always_comb begin
		logic [10:0] raw;
		logic [10:0] cap;
		raw = period_of(tb.sample_rate);
		cap = cap_of(tb.mode, tb.tap_filter_enable);
		// filter off: quarter of the sample period, half in low power, one unit at least
		if (!tb.tap_filter_enable) begin
			raw = (tb.mode == TAPT_MODE_LP) ? raw >> 1 : raw >> 2;
			if (raw < `TAPT_UNIT_ONE) begin
				raw = `TAPT_UNIT_ONE;
			end
		end
		dur_step = (raw < cap) ? raw : cap;
		lat_step = {dur_step[9:0], 1'b0};
	end

endmodule

// File: hw/tapt_pulse_timer.sv
// Notes on behaviour
// - a tap counts only if it falls below threshold within the duration limit
// - longest duration is the duration step times 255
// - duration step depends on sample rate, power mode and tap filter
// - filter on: duration step 1.25 ms at 800 Hz, doubling, capped per mode
// - filter off: duration step 0.625 ms at 800/400 Hz (800 Hz only in low power), doubling, capped per mode
// - after a first pulse a dead time runs; pulses inside it are ignored
// - longest dead time is the dead-time step times 255
// - filter on: dead-time step 2.5 ms at 800 Hz, doubling, capped per mode
// - filter off: dead-time step 1.25 ms at 800/400 Hz (800 Hz only in low power), doubling, capped
// - for double taps, second pulse must start in a window after dead time
// - a second pulse not shorter than the duration limit is rejected
// - second pulse may end after the window closed if it started inside
// - longest window is the window step times 255
// - filter on: window step equals the dead-time step
// - filter off: window step 1.25 ms at 800 Hz, capped per mode
// - tap filter enable comes from the high-pass filter configuration
// - each axis threshold is a 7-bit unsigned value against magnitude
// - reading the event source clears all its bits and the event
`timescale 1ns/100ps
`include "tapt_defs.svh"

module tapt_pulse_timer
	import tapt_pkg::*;
#(
	parameter int unsigned BASE_CYCLES = `TAPT_BASE_TICK_NS / `TAPT_CLK_PERIOD_NS
)(
	input  wire logic           ref_clk,
	input  wire logic           reset,
	input  wire logic [7:0]     reg_addr,
	input  wire logic [7:0]     reg_wdata,
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	output logic [7:0]          reg_rdata,
	input  wire tapt_timebase_t timebase,
	input  wire logic           sample_strobe,
	input  wire tapt_axes_t     axes,
	output logic                tap_single_event,
	output logic                tap_double_event,
	output logic                tap_event_active
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] evt_cfg, next_evt_cfg;
	logic [7:0] tap_event_source, next_tap_event_source;
	logic [6:0] axis_tap_threshold [3];
	logic [6:0] next_axis_tap_threshold [3];
	logic [7:0] tap_duration_limit, next_tap_duration_limit;
	logic [7:0] tap_latency_time, next_tap_latency_time;
	logic [7:0] tap_second_window, next_tap_second_window;
	logic [7:0] next_reg_rdata;

	// ----------------------------------------------------------------
	// detector state
	// ----------------------------------------------------------------
	tapt_state_t state, next_state;
	logic [16:0] pre_cnt, next_pre_cnt;
	logic [10:0] sub_cnt, next_sub_cnt;
	logic [7:0]  tcnt, next_tcnt;
	logic [2:0]  prev_above, next_prev_above;
	logic [1:0]  axis, next_axis;
	logic        next_single, next_double;
	logic [2:0]  above;
	logic [10:0] dur_step, lat_step, step_units;
	logic        base_tick, step_tick;
	logic        evt_fire, evt_dbl;

	tapt_step_sel u_step (
		.tb       (timebase),
		.dur_step (dur_step),
		.lat_step (lat_step)
	);

	function automatic logic [1:0] first_axis(input logic [2:0] v);
		first_axis = v[0] ? 2'h0 : (v[1] ? 2'h1 : 2'h2);
	endfunction

	function automatic logic single_en(input logic [7:0] c, input logic [1:0] a);
		single_en = c[{a, 1'b0}];
	endfunction

	function automatic logic double_en(input logic [7:0] c, input logic [1:0] a);
		double_en = c[{a, 1'b1}];
	endfunction

	// ----------------------------------------------------------------
	// threshold compare per axis
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_thr
			assign above[gi] = axes[gi].mag > {1'b0, axis_tap_threshold[gi]};
		end
	endgenerate

	assign base_tick  = pre_cnt == 17'(BASE_CYCLES - 1);
	assign step_units = (state == TAPT_LATENCY || state == TAPT_WINDOW) ? lat_step : dur_step;
	assign step_tick  = base_tick && (sub_cnt == step_units - `TAPT_UNIT_ONE);

	// ----------------------------------------------------------------
	// detector next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] rise;
		logic [2:0] armed;
		rise            = above & ~prev_above;
		armed           = {evt_cfg[5] | evt_cfg[4], evt_cfg[3] | evt_cfg[2],
			evt_cfg[1] | evt_cfg[0]};
		next_state      = state;
		next_axis       = axis;
		next_prev_above = sample_strobe ? above : prev_above;
		next_pre_cnt    = base_tick ? 17'h0 : pre_cnt + 17'h1;
		next_sub_cnt    = step_tick ? 11'h0 : (base_tick ? sub_cnt + 11'h1 : sub_cnt);
		next_tcnt       = (step_tick && tcnt != `TAPT_COUNT_FULL) ? tcnt + 8'h1 : tcnt;
		next_single     = 1'b0;
		next_double     = 1'b0;
		case (state)
			TAPT_IDLE: begin
				next_tcnt    = 8'h0;
				next_sub_cnt = 11'h0;
				if (sample_strobe && |(rise & armed)) begin
					next_axis  = first_axis(rise & armed);
					next_state = TAPT_PULSE1;
				end
			end
			TAPT_PULSE1: begin
				if (tcnt >= tap_duration_limit) begin
					next_state = TAPT_IDLE;
				end else if (sample_strobe && !above[axis]) begin
					next_single  = single_en(evt_cfg, axis);
					next_state   = TAPT_LATENCY;
					next_tcnt    = 8'h0;
					next_sub_cnt = 11'h0;
				end
			end
			TAPT_LATENCY: begin
				if (tcnt >= tap_latency_time) begin
					next_state   = double_en(evt_cfg, axis) ? TAPT_WINDOW : TAPT_IDLE;
					next_tcnt    = 8'h0;
					next_sub_cnt = 11'h0;
				end
			end
			TAPT_WINDOW: begin
				if (sample_strobe && rise[axis] && tcnt < tap_second_window) begin
					next_state   = TAPT_PULSE2;
					next_tcnt    = 8'h0;
					next_sub_cnt = 11'h0;
				end else if (tcnt >= tap_second_window) begin
					next_state = TAPT_IDLE;
				end
			end
			TAPT_PULSE2: begin
				if (tcnt >= tap_duration_limit) begin
					next_state = TAPT_IDLE;
				end else if (sample_strobe && !above[axis]) begin
					next_double = 1'b1;
					next_state  = TAPT_IDLE;
				end
			end
			default: begin
				next_state = TAPT_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state            <= TAPT_IDLE;
			axis             <= 2'h0;
			prev_above       <= 3'h0;
			pre_cnt          <= 17'h0;
			sub_cnt          <= 11'h0;
			tcnt             <= 8'h0;
			tap_single_event <= 1'b0;
			tap_double_event <= 1'b0;
		end else begin
			state            <= next_state;
			axis             <= next_axis;
			prev_above       <= next_prev_above;
			pre_cnt          <= next_pre_cnt;
			sub_cnt          <= next_sub_cnt;
			tcnt             <= next_tcnt;
			tap_single_event <= next_single;
			tap_double_event <= next_double;
		end
	end

	// ----------------------------------------------------------------
	// register file and event source
	// ----------------------------------------------------------------
	assign evt_fire = tap_single_event | tap_double_event;
	assign evt_dbl  = tap_double_event;

	always_comb begin
		logic rd_src;
		rd_src                  = reg_rd && reg_addr == `TAPT_OFS_EVT_SRC;
		next_evt_cfg            = evt_cfg;
		next_tap_duration_limit = tap_duration_limit;
		next_tap_latency_time   = tap_latency_time;
		next_tap_second_window  = tap_second_window;
		next_axis_tap_threshold = axis_tap_threshold;
		next_tap_event_source   = rd_src ? `TAPT_RST_BYTE : tap_event_source;
		// an event in the clearing cycle still lands; latch freezes otherwise
		if (evt_fire && !(evt_cfg[`TAPT_CFG_LATCH_BIT] && !rd_src
			&& tap_event_source[`TAPT_SRC_ACTIVE_BIT])) begin
			next_tap_event_source = `TAPT_RST_BYTE;
			next_tap_event_source[`TAPT_SRC_ACTIVE_BIT] = 1'b1;
			next_tap_event_source[3'(axis) + 3'h4]      = 1'b1;
			next_tap_event_source[`TAPT_SRC_DOUBLE_BIT] = evt_dbl;
			next_tap_event_source[axis]                 = axes[axis].neg;
		end
		if (reg_wr) begin
			case (reg_addr)
				`TAPT_OFS_EVT_CFG:  next_evt_cfg = reg_wdata;
				`TAPT_OFS_THR_X:    next_axis_tap_threshold[0] = reg_wdata[6:0];
				`TAPT_OFS_THR_Y:    next_axis_tap_threshold[1] = reg_wdata[6:0];
				`TAPT_OFS_THR_Z:    next_axis_tap_threshold[2] = reg_wdata[6:0];
				`TAPT_OFS_DURATION: next_tap_duration_limit = reg_wdata;
				`TAPT_OFS_LATENCY:  next_tap_latency_time = reg_wdata;
				`TAPT_OFS_WINDOW:   next_tap_second_window = reg_wdata;
				default: begin
				end
			endcase
		end
		next_reg_rdata = `TAPT_RST_BYTE;
		if (reg_rd) begin
			case (reg_addr)
				`TAPT_OFS_EVT_CFG:  next_reg_rdata = evt_cfg;
				`TAPT_OFS_EVT_SRC:  next_reg_rdata = tap_event_source;
				`TAPT_OFS_THR_X:    next_reg_rdata = {1'b0, axis_tap_threshold[0]};
				`TAPT_OFS_THR_Y:    next_reg_rdata = {1'b0, axis_tap_threshold[1]};
				`TAPT_OFS_THR_Z:    next_reg_rdata = {1'b0, axis_tap_threshold[2]};
				`TAPT_OFS_DURATION: next_reg_rdata = tap_duration_limit;
				`TAPT_OFS_LATENCY:  next_reg_rdata = tap_latency_time;
				`TAPT_OFS_WINDOW:   next_reg_rdata = tap_second_window;
				default:            next_reg_rdata = `TAPT_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			evt_cfg            <= `TAPT_RST_BYTE;
			tap_event_source   <= `TAPT_RST_BYTE;
			axis_tap_threshold <= '{default: `TAPT_RST_THR};
			tap_duration_limit <= `TAPT_RST_BYTE;
			tap_latency_time   <= `TAPT_RST_BYTE;
			tap_second_window  <= `TAPT_RST_BYTE;
			reg_rdata          <= `TAPT_RST_BYTE;
			tap_event_active   <= 1'b0;
		end else begin
			evt_cfg            <= next_evt_cfg;
			tap_event_source   <= next_tap_event_source;
			axis_tap_threshold <= next_axis_tap_threshold;
			tap_duration_limit <= next_tap_duration_limit;
			tap_latency_time   <= next_tap_latency_time;
			tap_second_window  <= next_tap_second_window;
			reg_rdata          <= next_reg_rdata;
			tap_event_active   <= next_tap_event_source[`TAPT_SRC_ACTIVE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	AST_SRC_CLEAR: assert property (
		reg_rd && reg_addr == `TAPT_OFS_EVT_SRC && !evt_fire |=> tap_event_source == 8'h00)
		else $error("event source not cleared by read");
	AST_DUR_FAIL: assert property (
		state == TAPT_PULSE1 && tcnt >= tap_duration_limit |=> state == TAPT_IDLE)
		else $error("over-long first pulse not rejected");
	AST_SECOND_FAIL: assert property (
		state == TAPT_PULSE2 && tcnt >= tap_duration_limit |=> state == TAPT_IDLE
		&& !tap_double_event)
		else $error("over-long second pulse accepted");
	AST_LAT_HOLD: assert property (
		state == TAPT_LATENCY && tcnt < tap_latency_time |=> state == TAPT_LATENCY
		&& !tap_double_event)
		else $error("pulse taken inside dead time");
	AST_WIN_CLOSE: assert property (
		state == TAPT_WINDOW && tcnt >= tap_second_window |=> state == TAPT_IDLE)
		else $error("window did not close");
	AST_STEP_RANGE: assert property (
		dur_step != 11'h0 && dur_step <= 11'h100 && lat_step == {dur_step[9:0], 1'b0})
		else $error("step out of range");
	AST_OFF_STEP: assert property (
		!timebase.tap_filter_enable |-> dur_step <= 11'h040)
		else $error("filter-off step too long");
	AST_DOUBLE_EVT: assert property (
		state == TAPT_PULSE2 && tcnt < tap_duration_limit && sample_strobe && !above[axis]
		|=> tap_double_event ##1 tap_event_source[`TAPT_SRC_DOUBLE_BIT])
		else $error("double tap not reported");
	AST_READ_ONE: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");

	COV_SINGLE: cover property (tap_single_event);
	COV_DOUBLE: cover property (tap_double_event);
	COV_WIN_TIMEOUT: cover property (state == TAPT_WINDOW ##1 state == TAPT_IDLE);
	COV_DUR_FAIL: cover property (state == TAPT_PULSE1 ##1 state == TAPT_IDLE);

endmodule

// File: bench/tb_top.sv
`timescale 1ns/100ps

module tb_top
	import tapt_pkg::*;
;

	logic           ref_clk;
	logic           reset;
	logic [7:0]     reg_addr;
	logic [7:0]     reg_wdata;
	logic           reg_wr;
	logic           reg_rd;
	logic [7:0]     reg_rdata;
	tapt_timebase_t timebase;
	logic           sample_strobe;
	tapt_axes_t     axes;
	logic           tap_single_event;
	logic           tap_double_event;
	logic           tap_event_active;
	logic [10:0]    e;
	logic           pol;
	logic [7:0]     v;
	integer         seed;
	int             fail_count;
	int             n_tests;
	int             sc;
	int             dc;
	int             s0;
	int             d0;
	int             cyc;
	int             i;

	tapt_pulse_timer #(.BASE_CYCLES(4)) tapt_pulse_timer_i (
		.ref_clk          (ref_clk),
		.reset            (reset),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_wr           (reg_wr),
		.reg_rd           (reg_rd),
		.reg_rdata        (reg_rdata),
		.timebase         (timebase),
		.sample_strobe    (sample_strobe),
		.axes             (axes),
		.tap_single_event (tap_single_event),
		.tap_double_event (tap_double_event),
		.tap_event_active (tap_event_active)
	);

	// ----------------------------------------------------------------
	// clock, event counters, hang guard
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (tap_single_event === 1'b1) sc <= sc + 1;
		if (tap_double_event === 1'b1) dc <= dc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// step in 0.625 ms units for duration; dead time and window are twice this
	function automatic logic [10:0] exp_dur(input logic [2:0] r, input logic [1:0] m,
			input logic f);
		logic [10:0] per;
		logic [10:0] val;
		logic [10:0] cap;
		per = (r < 3'h5) ? (11'h002 << r) : (r == 3'h5) ? 11'h080 :
			(r == 3'h6) ? 11'h100 : 11'h400;
		val = f ? per : (m == 2'h3) ? (per >> 1) : (per >> 2);
		if (val == 11'h000) val = 11'h001;
		case ({f, m})
			3'h0: cap = 11'h008;
			3'h1: cap = 11'h020;
			3'h2: cap = 11'h001;
			3'h3: cap = 11'h040;
			3'h4: cap = 11'h020;
			3'h5: cap = 11'h080;
			3'h6: cap = 11'h004;
			default: cap = 11'h100;
		endcase
		return (val < cap) ? val : cap;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		@(negedge ref_clk);
		check("reg_rdata", {3'h0, reg_rdata}, {3'h0, e});
	endtask

	// other axes stay at or below their full-scale threshold
	task automatic strobe(input logic [7:0] m);
		@(posedge ref_clk);
		sample_strobe <= 1'b1;
		axes <= {1'b0, 8'h7F & 8'($random(seed)), 1'b0, 8'h7F & 8'($random(seed)), pol, m};
		@(posedge ref_clk);
		sample_strobe <= 1'b0;
	endtask

	task automatic tap(input int w);
		strobe(8'h40);
		repeat (w) @(posedge ref_clk);
		strobe(8'h00);
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic evchk(input int es, input int ed);
		check("single_count", 11'(sc - s0), 11'(es));
		check("double_count", 11'(dc - d0), 11'(ed));
		s0 = sc;
		d0 = dc;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'hA0DF;
		fail_count = 0;
		n_tests = 0;
		sc = 0;
		dc = 0;
		cyc = 0;
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		timebase = '0;
		pol = 1'b0;
		sample_strobe = 1'b0;
		axes = '0;
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		rdchk(8'h26, 8'h00);
		rdchk(8'h27, 8'h00);
		rdchk(8'h28, 8'h00);
		for (i = 0; i < 3; i++) begin
			v = 8'($random(seed));
			wr(8'h26 + 8'(i), v);
			rdchk(8'h26 + 8'(i), v);
		end
		wr(8'h23, 8'hFF);
		rdchk(8'h23, 8'h7F);
		wr(8'h22, 8'hFF);
		rdchk(8'h22, 8'h00);
		rdchk(8'h30, 8'h00);
		for (i = 0; i < 64; i++) begin
			@(posedge ref_clk);
			timebase <= tapt_timebase_t'(6'(i));
			@(negedge ref_clk);
			e = exp_dur(3'(i >> 3), 2'(i >> 1), 1'(i));
			check("dur_step", tapt_pulse_timer_i.dur_step, e);
			check("lat_step", tapt_pulse_timer_i.lat_step, e << 1);
		end
		@(posedge ref_clk);
		timebase <= '0;
		wr(8'h21, 8'h01);
		wr(8'h23, 8'h20);
		wr(8'h24, 8'h7F);
		wr(8'h25, 8'h7F);
		wr(8'h26, 8'h0A);
		wr(8'h27, 8'h05);
		wr(8'h28, 8'h02);
		s0 = sc;
		d0 = dc;
		tap(10);
		evchk(1, 0);
		@(negedge ref_clk);
		check("event_active", {10'h000, tap_event_active}, 11'h001);
		rdchk(8'h22, 8'h90);
		check("event_active", {10'h000, tap_event_active}, 11'h000);
		rdchk(8'h22, 8'h00);
		repeat (60) @(posedge ref_clk);
		tap(10);
		tap(4);
		repeat (60) @(posedge ref_clk);
		tap(10);
		evchk(2, 0);
		rdchk(8'h22, 8'h90);
		tap(60);
		repeat (60) @(posedge ref_clk);
		evchk(0, 0);
		for (i = 0; i < 4; i++) begin
			tap(2 + ($random(seed) & 15));
			repeat (60) @(posedge ref_clk);
		end
		evchk(4, 0);
		wr(8'h26, 8'h00);
		tap(4);
		repeat (60) @(posedge ref_clk);
		evchk(0, 0);
		wr(8'h26, 8'h0A);
		wr(8'h21, 8'h02);
		wr(8'h27, 8'h02);
		rdchk(8'h22, 8'h90);
		tap(4);
		repeat (17) @(posedge ref_clk);
		tap(26);
		evchk(0, 1);
		rdchk(8'h22, 8'h98);
		repeat (100) @(posedge ref_clk);
		tap(4);
		repeat (17) @(posedge ref_clk);
		tap(60);
		repeat (100) @(posedge ref_clk);
		evchk(0, 0);
		tap(4);
		repeat (50) @(posedge ref_clk);
		tap(4);
		repeat (100) @(posedge ref_clk);
		evchk(0, 0);
		// latch: the first event freezes the source until it is read
		wr(8'h21, 8'h41);
		tap(4);
		repeat (40) @(posedge ref_clk);
		pol = 1'b1;
		tap(4);
		repeat (40) @(posedge ref_clk);
		evchk(2, 0);
		rdchk(8'h22, 8'h90);
		tap(4);
		repeat (40) @(posedge ref_clk);
		evchk(1, 0);
		rdchk(8'h22, 8'h91);
		pol = 1'b0;
		// filter on doubles the duration step, so a 52-cycle pulse now passes
		@(posedge ref_clk);
		timebase <= tapt_timebase_t'(6'h01);
		tap(50);
		repeat (100) @(posedge ref_clk);
		evchk(1, 0);
		conclude();
	end

endmodule
